// *** hw/dut_consts.vh ***
// Constants for the DAC update, toggle and power-down configuration block
//****************************************************************************
// Summary of operation
//****************************************************************************
// Summary of operation
// (R1) Sync channel waits for load trigger
// (R2) Async channel updates output on write
// (R3) Sync select: bit n channel n, reset zero
// (R4) Toggle field: 00 off, else source 0-2
// (R5) Offset 07h holds channels 15..8 fields
// (R6) Offset 08h holds channels 7..0 fields
// (R7) Toggle fields reset to zero
// (R8) Power-down at 09h, resets all ones
// (R9) Powered-down channel output held grounded
// (R10) Toggle channel picks A/B by source
`ifndef DUT_CONSTS_VH
`define DUT_CONSTS_VH

// Register indices; byte address is four times the index
`define DUT_IDX_SYNC      8'h06
`define DUT_IDX_TOGG_HI   8'h07
`define DUT_IDX_TOGG_LO   8'h08
`define DUT_IDX_PWDN      8'h09
`define DUT_IDX_DATA_A    8'h10
`define DUT_IDX_DATA_B    8'h11
`define DUT_IDX_DATA_CH   8'h12
`define DUT_IDX_STATUS    8'h13

// Reset values
`define DUT_RST_SYNC      16'h0000
`define DUT_RST_TOGG      16'h0000
`define DUT_RST_PWDN      16'hffff

// Toggle field encodings
`define DUT_TOGG_OFF      2'b00
`define DUT_TOGG_SRC0     2'b01
`define DUT_TOGG_SRC1     2'b10
`define DUT_TOGG_SRC2     2'b11

// AXI responses
`define DUT_RESP_OKAY     2'b00
`define DUT_RESP_SLVERR   2'b10

`endif

// *** hw/dut_sync2.v ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module dut_sync2 #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             reset_n,
  // Data
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;

  // First flop feeds only the second
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= {WIDTH{1'b0}};
      stage2_q <= {WIDTH{1'b0}};
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;
endmodule // dut_sync2

// *** hw/dut_channel.v ***
// One output channel: pending/active codes, toggle and power-down
`timescale 1ns/1ns
`include "dut_consts.vh"
module dut_channel #(
  parameter DW = 16
) (
  // Clock and reset
  input  wire          core_clk,
  input  wire          reset_n,
  // Configuration
  input  wire          channelWaitForLoad,
  input  wire [1:0]    channelToggleSource,
  input  wire          channelOffBit,
  // Data writes and trigger
  input  wire          writeA,
  input  wire          writeB,
  input  wire [DW-1:0] wrData,
  input  wire          loadPulse,
  input  wire [2:0]    toggleLevels,
  // Result
  output reg  [DW-1:0] outCode,
  output reg           pending
);
  reg [DW-1:0] pendA_q;
  reg [DW-1:0] pendB_q;
  reg [DW-1:0] actA_q;
  reg [DW-1:0] actB_q;
  reg          selB;

  // Pending and active code registers
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pendA_q <= {DW{1'b0}};
      pendB_q <= {DW{1'b0}};
      actA_q  <= {DW{1'b0}};
      actB_q  <= {DW{1'b0}};
      pending <= 1'b0;
    end else begin
      if (writeA) begin
        pendA_q <= wrData;
      end
      if (writeB) begin
        pendB_q <= wrData;
      end
      if (!channelWaitForLoad) begin
        // Immediate update
        if (writeA) actA_q <= wrData;          // R2
        if (writeB) actB_q <= wrData;          // R2
        pending <= 1'b0;
      end else if (loadPulse) begin
        // Held data moves only on trigger
        actA_q  <= writeA ? wrData : pendA_q;  // R1
        actB_q  <= writeB ? wrData : pendB_q;  // R1
        pending <= 1'b0;
      end else if (writeA || writeB) begin
        pending <= 1'b1;                       // R1
      end
    end
  end

  // Toggle source selection
  always @* begin
    case (channelToggleSource)                 // R4
      `DUT_TOGG_OFF:  selB = 1'b0;
      `DUT_TOGG_SRC0: selB = toggleLevels[0];
      `DUT_TOGG_SRC1: selB = toggleLevels[1];
      `DUT_TOGG_SRC2: selB = toggleLevels[2];
      default:        selB = 1'b0;
    endcase
  end

  // Registered output code, grounded while off
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      outCode <= {DW{1'b0}};
    end else if (channelOffBit) begin
      outCode <= {DW{1'b0}};                   // R9
    end else begin
      outCode <= selB ? actB_q : actA_q;       // R10
    end
  end
endmodule // dut_channel

// *** hw/dut_cfg_top.v ***
// Top: AXI4-Lite register bank driving sixteen output channels
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "dut_consts.vh"
module dut_cfg_top #(
  parameter NCH = 16,
  parameter DW  = 16
) (
  // Clock and reset
  input  wire              core_clk,
  input  wire              reset_n,
  // AXI4-Lite write address
  input  wire [11:0]       s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0]       s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Pins
  input  wire              load_trigger_pin_n,
  input  wire              toggle_source_zero,
  input  wire              toggle_source_one,
  input  wire              toggle_source_two,
  // Channel outputs
  output wire [NCH*DW-1:0] chanCode,
  output wire [NCH-1:0]    channel_off_bit
);
  //**************************************************************************
  // Registers
  //**************************************************************************
  reg  [15:0]        syncUpdateSelect_q;
  reg  [15:0]        toggleSelectHigh_q;
  reg  [15:0]        toggleSelectLow_q;
  reg  [15:0]        channelPowerDown_q;
  reg  [3:0]         dataChannel_q;
  reg                awHeld_q;
  reg                wHeld_q;
  reg  [9:0]         awIdx_q;
  reg  [31:0]        wData_q;
  reg  [3:0]         wStrb_q;
  reg                loadLevelPrev_q;
  reg                loadPulse_q;
  reg  [31:0]        readWord;
  reg                readHit;
  wire [3:0]         pinSync;
  wire [NCH*DW-1:0]  codeAll;
  wire [NCH-1:0]     pendAll;
  wire [31:0]        channelToggleSource;
  wire               doWrite;
  wire               writeHit;
  wire [9:0]         arIdx;

  //**************************************************************************
  // Pin synchronisation
  //**************************************************************************
  dut_sync2 #(
    .WIDTH (4)
  ) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .asyncIn  ({toggle_source_two, toggle_source_one,
                toggle_source_zero, load_trigger_pin_n}),
    .syncOut  (pinSync)
  );

  // Falling edge of the trigger pin becomes a load pulse
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      loadLevelPrev_q <= 1'b0;  // Matches synchroniser reset, no false edge
      loadPulse_q     <= 1'b0;
    end else begin
      loadLevelPrev_q <= pinSync[0];
      loadPulse_q     <= loadLevelPrev_q & ~pinSync[0];  // R1
    end
  end

  //**************************************************************************
  // Write channel
  //**************************************************************************
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  // Capture address and data in either order
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      awIdx_q       <= 10'h000;
      wData_q       <= 32'h00000000;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DUT_RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !awHeld_q && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        awHeld_q      <= 1'b1;
        awIdx_q       <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && !wHeld_q && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        wHeld_q      <= 1'b1;
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= writeHit ? `DUT_RESP_OKAY : `DUT_RESP_SLVERR;
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Decode of the held write address
  assign writeHit = (awIdx_q == {2'b00, `DUT_IDX_SYNC})
                 || (awIdx_q == {2'b00, `DUT_IDX_TOGG_HI})
                 || (awIdx_q == {2'b00, `DUT_IDX_TOGG_LO})
                 || (awIdx_q == {2'b00, `DUT_IDX_PWDN})
                 || (awIdx_q == {2'b00, `DUT_IDX_DATA_A})
                 || (awIdx_q == {2'b00, `DUT_IDX_DATA_B})
                 || (awIdx_q == {2'b00, `DUT_IDX_DATA_CH});

  // Configuration registers, byte lanes honoured
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncUpdateSelect_q <= `DUT_RST_SYNC;              // R3
      toggleSelectHigh_q <= `DUT_RST_TOGG;              // R7
      toggleSelectLow_q  <= `DUT_RST_TOGG;              // R7
      channelPowerDown_q <= `DUT_RST_PWDN;              // R8
      dataChannel_q      <= 4'h0;
    end else if (doWrite && writeHit) begin
      case (awIdx_q[7:0])
        `DUT_IDX_SYNC: begin                            // R3
          if (wStrb_q[0]) syncUpdateSelect_q[7:0]  <= wData_q[7:0];
          if (wStrb_q[1]) syncUpdateSelect_q[15:8] <= wData_q[15:8];
        end
        `DUT_IDX_TOGG_HI: begin                         // R5
          if (wStrb_q[0]) toggleSelectHigh_q[7:0]  <= wData_q[7:0];
          if (wStrb_q[1]) toggleSelectHigh_q[15:8] <= wData_q[15:8];
        end
        `DUT_IDX_TOGG_LO: begin                         // R6
          if (wStrb_q[0]) toggleSelectLow_q[7:0]  <= wData_q[7:0];
          if (wStrb_q[1]) toggleSelectLow_q[15:8] <= wData_q[15:8];
        end
        `DUT_IDX_PWDN: begin                            // R8
          if (wStrb_q[0]) channelPowerDown_q[7:0]  <= wData_q[7:0];
          if (wStrb_q[1]) channelPowerDown_q[15:8] <= wData_q[15:8];
        end
        `DUT_IDX_DATA_CH: begin
          if (wStrb_q[0]) dataChannel_q <= wData_q[3:0];
        end
        default: begin
          dataChannel_q <= dataChannel_q;
        end
      endcase
    end
  end

  //**************************************************************************
  // Channels
  //**************************************************************************
  // Low register holds channels 7..0, high register channels 15..8
  assign channelToggleSource = {toggleSelectHigh_q, toggleSelectLow_q};

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
      wire wrA;
      wire wrB;
      assign wrA = doWrite && writeHit
                && (awIdx_q[7:0] == `DUT_IDX_DATA_A)
                && ({28'h0000000, dataChannel_q} == gi) && (&wStrb_q[1:0]);
      assign wrB = doWrite && writeHit
                && (awIdx_q[7:0] == `DUT_IDX_DATA_B)
                && ({28'h0000000, dataChannel_q} == gi) && (&wStrb_q[1:0]);
      dut_channel #(
        .DW (DW)
      ) u_ch (
        .core_clk            (core_clk),
        .reset_n             (reset_n),
        .channelWaitForLoad  (syncUpdateSelect_q[gi]),          // R1
        .channelToggleSource (channelToggleSource[2*gi+1:2*gi]), // R4
        .channelOffBit       (channelPowerDown_q[gi]),          // R9
        .writeA              (wrA),
        .writeB              (wrB),
        .wrData              (wData_q[DW-1:0]),
        .loadPulse           (loadPulse_q),
        .toggleLevels        (pinSync[3:1]),
        .outCode             (codeAll[gi*DW +: DW]),
        .pending             (pendAll[gi])
      );
    end
  endgenerate

  assign chanCode        = codeAll;
  assign channel_off_bit = channelPowerDown_q;  // R9

  //**************************************************************************
  // Read channel
  //**************************************************************************
  assign arIdx = s_axi_araddr[11:2];

  // Read mux, upper bits zero
  always @* begin
    readWord = 32'h00000000;
    readHit  = 1'b1;
    case (arIdx[7:0])
      `DUT_IDX_SYNC:    readWord[15:0] = syncUpdateSelect_q;
      `DUT_IDX_TOGG_HI: readWord[15:0] = toggleSelectHigh_q;
      `DUT_IDX_TOGG_LO: readWord[15:0] = toggleSelectLow_q;
      `DUT_IDX_PWDN:    readWord[15:0] = channelPowerDown_q;
      `DUT_IDX_DATA_CH: readWord[3:0]  = dataChannel_q;
      `DUT_IDX_STATUS:  readWord[NCH-1:0] = pendAll;
      `DUT_IDX_DATA_A:  readWord = 32'h00000000;
      `DUT_IDX_DATA_B:  readWord = 32'h00000000;
      default:          readHit = 1'b0;
    endcase
    if (arIdx[9:8] != 2'b00) begin
      readHit = 1'b0;
    end
  end

  // One read at a time; answer in the same cycle as acceptance
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `DUT_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= readHit ? readWord : 32'h00000000;
        s_axi_rresp   <= readHit ? `DUT_RESP_OKAY : `DUT_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // dut_cfg_top

// *** tb/dut_cfg_monitor.sv ***
// Bus handshake and channel output checks on the top ports
`timescale 1ns/1ns
module dut_cfg_monitor #(
  parameter NCH = 16,
  parameter DW  = 16
) (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              reset_n,
  // Register bus
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Channel outputs
  input wire logic [NCH*DW-1:0] chanCode,
  input wire logic [NCH-1:0]    channel_off_bit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  //****************************************************************
  // Assertions
  //****************************************************************
  property p_awPulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_awPulse: assert property (p_awPulse) else $error("awready too long");
  property p_wOnValid; s_axi_wready |-> s_axi_wvalid; endproperty
  a_wOnValid: assert property (p_wOnValid) else $error("wready unasked");
  property p_bAfter; s_axi_awready && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_bAfter: assert property (p_bAfter) else $error("bvalid late");
  property p_bHold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bHold: assert property (p_bHold) else $error("bvalid dropped");
  property p_rAns; s_axi_arvalid && s_axi_arready |-> s_axi_rvalid;
  endproperty
  a_rAns: assert property (p_rAns) else $error("rvalid missing");
  property p_rHold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rHold: assert property (p_rHold) else $error("rvalid dropped");
  property p_rUpper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rUpper: assert property (p_rUpper) else $error("upper read nonzero");
  property p_offCode; channel_off_bit[0] [*2] |-> chanCode[DW-1:0] == '0;
  endproperty
  a_offCode: assert property (p_offCode) else $error("off code live");
  property p_offWrite; $changed(channel_off_bit) |-> s_axi_bvalid;
  endproperty
  a_offWrite: assert property (p_offWrite) else $error("off bit drift");
endmodule // dut_cfg_monitor
bind dut_cfg_top dut_cfg_monitor #(.NCH(NCH), .DW(DW)) u_dut_cfg_monitor (
  .core_clk(core_clk), .reset_n(reset_n), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .chanCode(chanCode), .channel_off_bit(channel_off_bit));

// *** tb/dut_pin_model.sv ***
// Load trigger and toggle pin drivers standing at the far side
`timescale 1ns/1ns
module dut_pin_model (
  // Clock
  input wire logic       core_clk,
  // Requests from the bench
  input wire logic       loadReq,
  input wire logic [2:0] togReq,
  // Pins
  output logic           load_trigger_pin_n,
  output logic [2:0]     togPins
);
  // Pins idle high for load, low for toggles
  initial begin
    load_trigger_pin_n = 1'b1;
    togPins = 3'b000;
  end
  // Pins move just after the edge
  always @(posedge core_clk) begin
    load_trigger_pin_n <= ~loadReq;
    togPins <= togReq;
  end
endmodule // dut_pin_model

// *** tb/test_dac_update_toggle_powerdown_cfg.sv ***
// Self-checking bench for the update, toggle and power-down block
`timescale 1ns/1ns
`include "dut_consts.vh"
module test_dac_update_toggle_powerdown_cfg;
  logic core_clk = 0, reset_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0] ws = 0;
  logic [1:0] br, rr;
  logic awr, wr_, bv, arr, rv, loadReq = 0, ldN;
  logic [2:0] togReq = 0, tog;
  logic [255:0] chanCode;
  logic [15:0] offBit;
  logic [31:0] got;
  logic [1:0] resp;
  int nFail = 0, samplesChecked = 0;
  always #5 core_clk = ~core_clk;
  dut_cfg_top u_dut_cfg_top (.core_clk(core_clk), .reset_n(reset_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .load_trigger_pin_n(ldN),
    .toggle_source_zero(tog[0]), .toggle_source_one(tog[1]),
    .toggle_source_two(tog[2]), .chanCode(chanCode),
    .channel_off_bit(offBit));
  dut_pin_model u_dut_pin_model (.core_clk(core_clk), .loadReq(loadReq),
    .togReq(togReq), .load_trigger_pin_n(ldN), .togPins(tog));
  //****************************************************************
  // Shared tasks
  //****************************************************************
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samplesChecked++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      nFail++;
    end
  endtask
  // Write one register word; ready and response taken at rising edges
  task automatic wrReg(input logic [7:0] idx, input logic [15:0] d);
    logic bDone;
    int n;
    bDone = 1'b0;
    @(posedge core_clk);
    awa <= {2'b00, idx, 2'b00}; wd <= {16'h0000, d}; ws <= 4'hf;
    awv <= 1; wv <= 1; bry <= 1;
    for (n = 0; n < 40 && !bDone; n++) begin
      @(posedge core_clk);
      if (awv && awr) awv <= 0;
      if (wv && wr_) wv <= 0;
      if (bv) begin
        bry <= 0;
        resp = br;
        bDone = 1'b1;
      end
    end
    chk({31'h0, bDone}, 32'h1);
  endtask
  // Read one register word; data taken at the edge rvalid is seen
  task automatic rdReg(input logic [7:0] idx);
    logic rDone;
    int n;
    rDone = 1'b0;
    @(posedge core_clk);
    ara <= {2'b00, idx, 2'b00}; arv <= 1; rry <= 1;
    for (n = 0; n < 40 && !rDone; n++) begin
      @(posedge core_clk);
      if (arv && arr) arv <= 0;
      if (rv) begin
        rry <= 0;
        got = rd;
        resp = rr;
        rDone = 1'b1;
      end
    end
    chk({31'h0, rDone}, 32'h1);
  endtask
  task automatic waitCyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  //****************************************************************
  // Scenarios
  //****************************************************************
  task automatic tReset;
    rdReg(`DUT_IDX_SYNC); chk(got, 32'h0000_0000);
    rdReg(`DUT_IDX_TOGG_HI); chk(got, 32'h0000_0000);
    rdReg(`DUT_IDX_TOGG_LO); chk(got, 32'h0000_0000);
    rdReg(`DUT_IDX_PWDN); chk(got, 32'h0000_ffff);
    chk(offBit, 32'h0000_ffff);
    $display("test reset done");
  endtask
  task automatic tFields;
    logic [7:0] idx [3] = '{`DUT_IDX_TOGG_HI, `DUT_IDX_TOGG_LO, `DUT_IDX_SYNC};
    int i;
    for (i = 0; i < 3; i++) begin
      wrReg(idx[i], 16'h9c36 ^ i[15:0]);
      rdReg(idx[i]); chk(got, 32'h9c36 ^ i);
    end
    wrReg(`DUT_IDX_PWDN, 16'h0000); chk(offBit, 32'h0);
    chk(resp, `DUT_RESP_OKAY);
    rdReg(8'h3f); chk(resp, `DUT_RESP_SLVERR);
    chk(got, 32'h0);
    wrReg(8'h3f, 16'h1111); chk(resp, `DUT_RESP_SLVERR);
    rdReg(`DUT_IDX_PWDN); chk(got, 32'h0);
    wrReg(`DUT_IDX_SYNC, 16'h0000);
    wrReg(`DUT_IDX_TOGG_HI, 16'h0000);
    wrReg(`DUT_IDX_TOGG_LO, 16'h0000);
    $display("test fields done");
  endtask
  task automatic tUpdate;
    wrReg(`DUT_IDX_DATA_CH, 16'h0003);
    wrReg(`DUT_IDX_DATA_A, 16'h1234); waitCyc(3);
    chk(chanCode[48+:16], 32'h1234);
    wrReg(`DUT_IDX_SYNC, 16'h0008);
    wrReg(`DUT_IDX_DATA_A, 16'h5555); waitCyc(6);
    chk(chanCode[48+:16], 32'h1234);
    rdReg(`DUT_IDX_STATUS); chk(got, 32'h0000_0008);
    @(posedge core_clk) loadReq <= 1;
    repeat (3) @(posedge core_clk);
    loadReq <= 0; waitCyc(8);
    chk(chanCode[48+:16], 32'h5555);
    rdReg(`DUT_IDX_STATUS); chk(got, 32'h0000_0000);
    wrReg(`DUT_IDX_SYNC, 16'h0000);
    $display("test update done");
  endtask
  // Fields for sources 0..2, then off; channel 3 then channel 12
  task automatic tToggle;
    int s;
    wrReg(`DUT_IDX_DATA_B, 16'hbbbb);
    for (s = 0; s < 4; s++) begin
      wrReg(`DUT_IDX_TOGG_LO, (s < 3 ? s + 1 : 0) << 6);
      @(posedge core_clk) togReq <= 3'b111 & ((s < 3) ? 1 << s : 7);
      waitCyc(6); chk(chanCode[48+:16], s < 3 ? 32'hbbbb : 32'h5555);
      @(posedge core_clk) togReq <= 3'b000;
      waitCyc(6); chk(chanCode[48+:16], 32'h5555);
    end
    wrReg(`DUT_IDX_DATA_CH, 16'h000c);
    wrReg(`DUT_IDX_DATA_A, 16'h00aa); wrReg(`DUT_IDX_DATA_B, 16'h00bb);
    wrReg(`DUT_IDX_TOGG_HI, 16'h0300);
    @(posedge core_clk) togReq <= 3'b100;
    waitCyc(6); chk(chanCode[192+:16], 32'h00bb);
    $display("test toggle done");
  endtask
  task automatic tPowerDown;
    wrReg(`DUT_IDX_PWDN, 16'h0008); waitCyc(3);
    chk(offBit, 32'h0008);
    chk(chanCode[48+:16], 32'h0);
    chk(chanCode[192+:16], 32'h00bb);
    $display("test power down done");
  endtask
  //****************************************************************
  // Verdict, watchdog and main sequence
  //****************************************************************
  task automatic closeOut;
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #50000;
    nFail++;
    closeOut();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1;
    tReset(); tFields(); tUpdate(); tToggle(); tPowerDown();
    closeOut();
  end
endmodule // test_dac_update_toggle_powerdown_cfg
